// File: lcs_top.sv
// Source selection stage for four configurable logic cells.
// Each cell has four 8:1 data multiplexers steered by one register.
// Pin and foreign-clock sources are synchronised; peripheral events
// are assumed to be produced on clk_i already.
`timescale 1ns/1ns
module lcs_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [lcs_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // asynchronous sources: pins and foreign clocks
  input wire logic logic_cell_input_a_i,
  input wire logic logic_cell_input_b_i,
  input wire logic system_clock_sig_i,
  input wire logic hs_pwm_clock_i,
  input wire logic internal_oscillator_clock_i,
  input wire logic reference_clock_output_i,
  // timers and pwm generators, index 0 is generator 1
  input wire logic timer1_match_i,
  input wire logic timer2_match_i,
  input wire logic timer3_match_i,
  input wire logic [7:0] pwm_gen_high_i,
  input wire logic [7:0] pwm_gen_low_i,
  // analog, dma and capture events
  input wire logic comparator_1_output_i,
  input wire logic comparator_2_output_i,
  input wire logic comparator_3_output_i,
  input wire logic adc_end_of_conv_i,
  input wire logic dma_ch0_irq_i,
  input wire logic dma_ch1_irq_i,
  input wire logic pattern_trigger_i,
  input wire logic can_msg_i,
  input wire logic pwm_current_reset_i,
  input wire logic [2:0] output_compare_i,
  input wire logic [1:0] input_capture_i,
  // serial lines, index 0 is channel 1
  input wire logic [1:0] uart_tx_i,
  input wire logic [1:0] uart_rx_i,
  input wire logic [1:0] spi_sdo_i,
  input wire logic [1:0] spi_sdi_i,
  // cell outputs fed back from the logic stage
  input wire logic [3:0] cell_out_i,
  // data lines, index is cell*4 + mux
  output logic [15:0] data_true_o,
  output logic [15:0] data_neg_o
);
  import lcs_pkg::*;

  typedef struct packed {
    logic [NUM_ASYNC-1:0] sync1;
    logic [NUM_ASYNC-1:0] sync2;
  } lcs_top_state_t;
  lcs_top_state_t state;
  lcs_top_state_t next_state;

  lcs_reg_t sel_reg [NUM_CELLS];
  logic [7:0] src [NUM_CELLS][NUM_MUX];
  lcs_sel_t mux_sel [NUM_CELLS][NUM_MUX];

  // synchronised copies
  logic in_a;
  logic in_b;
  logic sys_clk;
  logic hs_clk;
  logic osc_clk;
  logic ref_clk;

  always_comb begin
    next_state = state;
    // two flops; only sync2 is read by logic
    next_state.sync1 = {reference_clock_output_i, internal_oscillator_clock_i,
                        hs_pwm_clock_i, system_clock_sig_i,
                        logic_cell_input_b_i, logic_cell_input_a_i};
    next_state.sync2 = state.sync1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= '{sync1: '0, sync2: '0};
    end else begin
      state <= next_state;
    end
  end

  assign in_a = state.sync2[0];
  assign in_b = state.sync2[1];
  // clock sources are sampled, so only slow clocks pass faithfully
  assign sys_clk = state.sync2[2];
  assign hs_clk = state.sync2[3];
  assign osc_clk = state.sync2[4];
  assign ref_clk = state.sync2[5];

  lcs_wb_regs u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .sel_reg_o(sel_reg)
  );

  always_comb begin
    for (int c = 0; c < NUM_CELLS; c++) begin
      mux_sel[c][0] = sel_reg[c][MUX1_POS +: SEL_W];
      mux_sel[c][1] = sel_reg[c][MUX2_POS +: SEL_W];
      mux_sel[c][2] = sel_reg[c][MUX3_POS +: SEL_W];
      mux_sel[c][3] = sel_reg[c][MUX4_POS +: SEL_W];
    end
  end

  // source tables, bit n of each vector is code n
  always_comb begin
    src[0][0] = {timer3_match_i, timer2_match_i, hs_clk, pwm_gen_low_i[4],
                 pwm_gen_high_i[0], timer1_match_i, sys_clk, in_a};
    src[0][1] = {pwm_gen_high_i[4], pwm_gen_low_i[0], dma_ch0_irq_i, adc_end_of_conv_i,
                 uart_tx_i[0], comparator_1_output_i, cell_out_i[1], in_b};
    src[0][2] = {output_compare_i[1], pwm_gen_low_i[5], pwm_gen_high_i[1], uart_rx_i[0],
                 spi_sdo_i[0], comparator_2_output_i, cell_out_i[0], in_a};
    src[0][3] = {pwm_gen_high_i[5], pwm_gen_low_i[1], can_msg_i, pattern_trigger_i,
                 spi_sdi_i[0], comparator_3_output_i, cell_out_i[1], in_b};
    src[1][0] = {timer3_match_i, timer2_match_i, hs_clk, pwm_gen_low_i[6],
                 pwm_gen_high_i[2], timer1_match_i, sys_clk, in_a};
    src[1][1] = {pwm_gen_high_i[6], pwm_gen_low_i[2], dma_ch0_irq_i, adc_end_of_conv_i,
                 uart_tx_i[1], comparator_1_output_i, cell_out_i[0], in_b};
    src[1][2] = {output_compare_i[1], pwm_gen_low_i[7], pwm_gen_high_i[3], uart_rx_i[1],
                 spi_sdo_i[1], comparator_2_output_i, cell_out_i[1], in_a};
    src[1][3] = {pwm_gen_high_i[7], pwm_gen_low_i[3], can_msg_i, pattern_trigger_i,
                 spi_sdi_i[1], comparator_3_output_i, cell_out_i[0], in_b};
    // cell 3 mux 1, code 100 has no source
    src[2][0] = {pwm_gen_low_i[2], timer2_match_i, hs_clk, 1'b0,
                 pwm_gen_high_i[4], timer1_match_i, sys_clk, in_a};
    src[2][1] = {input_capture_i[1], input_capture_i[0], pwm_gen_high_i[2], adc_end_of_conv_i,
                 pwm_gen_low_i[4], comparator_1_output_i, cell_out_i[3], in_b};
    src[2][2] = {pwm_gen_low_i[3], output_compare_i[0], dma_ch1_irq_i, uart_rx_i[0],
                 pwm_gen_high_i[5], comparator_2_output_i, cell_out_i[2], in_a};
    src[2][3] = {output_compare_i[2], pwm_current_reset_i, pwm_gen_high_i[3], pattern_trigger_i,
                 pwm_gen_low_i[5], comparator_3_output_i, cell_out_i[3], in_b};
    src[3][0] = {pwm_gen_low_i[0], timer2_match_i, hs_clk, ref_clk,
                 osc_clk, timer1_match_i, pwm_gen_high_i[6], in_a};
    src[3][1] = {input_capture_i[1], input_capture_i[0], pwm_gen_high_i[0], adc_end_of_conv_i,
                 pwm_gen_low_i[6], comparator_1_output_i, cell_out_i[2], in_b};
    src[3][2] = {pwm_gen_low_i[1], output_compare_i[0], dma_ch1_irq_i, uart_rx_i[1],
                 pwm_gen_high_i[7], comparator_2_output_i, cell_out_i[3], in_a};
    src[3][3] = {output_compare_i[2], pwm_current_reset_i, pwm_gen_high_i[1], pattern_trigger_i,
                 pwm_gen_low_i[7], comparator_3_output_i, cell_out_i[2], in_b};
  end

  // registered muxes keep glitches from feeding the gate stage
  for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
    for (genvar m = 0; m < NUM_MUX; m++) begin : g_mux
      lcs_src_mux u_mux (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .src_i(src[c][m]),
        .sel_i(mux_sel[c][m]),
        .true_o(data_true_o[c*NUM_MUX+m]),
        .neg_o(data_neg_o[c*NUM_MUX+m])
      );
    end
  end
endmodule

// File: lcs_pkg.sv
// Constants and types for the logic cell source select block.
// Assumes a classic Wishbone master and on-chip sources on clk_i.
// Summary of operation
// - Bits 14..12 pick which of eight signals feeds data multiplexer 4.
// - Bits 10..8 pick which of eight signals feeds data multiplexer 3.
// - Bits 6..4 pick which of eight signals feeds data multiplexer 2.
// - Bits 2..0 pick which of eight signals feeds data multiplexer 1.
// - Unused bits 15, 11, 7 and 3 always read as zero.
// - Reset clears every selector to zero; all selector bits read and write.
// - Cell 1 mux 1: input A, sysclk, T1, gen1H, gen5L, HS clock, T2, T3.
// - Cell 2 mux 1: input A, sysclk, T1, gen3H, gen7L, HS clock, T2, T3.
// - Cell 3 mux 1: 000 input A, 011 gen5H, 101 hsclk, 110 T2, 111 gen3L.
// - Cell 4 mux 1: input A, gen7H, T1, osc clock, ref clock, HS, T2, gen1L.
// - Cells 1, 2 mux 2: input B, other cell, comp 1, UART TX, ADC, DMA0.
// - Cells 3, 4 mux 3: 000 input A, 010 comp 2, 101 DMA1, 110 compare 1.
// - Each multiplexer gives a true and an inverted copy of its source.
package lcs_pkg;
  localparam int NUM_CELLS = 4;
  localparam int NUM_MUX = 4;
  localparam int SEL_W = 3;
  localparam int REG_W = 16;
  localparam int ADR_W = 8;
  // one word per cell register
  localparam logic [ADR_W-1:0] CELL1_SEL_OFFSET = 8'h00;
  localparam logic [ADR_W-1:0] CELL2_SEL_OFFSET = 8'h04;
  localparam logic [ADR_W-1:0] CELL3_SEL_OFFSET = 8'h08;
  localparam logic [ADR_W-1:0] CELL4_SEL_OFFSET = 8'h0C;
  localparam int MUX1_POS = 0;
  localparam int MUX2_POS = 4;
  localparam int MUX3_POS = 8;
  localparam int MUX4_POS = 12;
  localparam logic [REG_W-1:0] SEL_IMPL_MASK = 16'h7777;
  localparam logic [REG_W-1:0] SEL_RESET = 16'h0000;
  localparam int SYNC_STAGES = 2;
  localparam int NUM_ASYNC = 6;
  typedef logic [REG_W-1:0] lcs_reg_t;
  typedef logic [SEL_W-1:0] lcs_sel_t;
endpackage

// File: lcs_src_mux.sv
// One data multiplexer: eight sources in, registered true and negated copies out.
// Assumes all sources are already in the clk_i domain.
`timescale 1ns/1ns
module lcs_src_mux (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // selection
  input wire logic [7:0] src_i,
  input wire lcs_pkg::lcs_sel_t sel_i,
  // data lines
  output logic true_o,
  output logic neg_o
);
  import lcs_pkg::*;
  typedef struct packed {
    logic d_true;
    logic d_neg;
  } lcs_mux_state_t;
  lcs_mux_state_t state;
  lcs_mux_state_t next_state;
  always_comb begin
    next_state = state;
    next_state.d_true = src_i[sel_i];
    next_state.d_neg = ~src_i[sel_i];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // held complementary even in reset so a gate never sees both low
      state <= '{d_true: 1'b0, d_neg: 1'b1};
    end else begin
      state <= next_state;
    end
  end
  assign true_o = state.d_true;
  assign neg_o = state.d_neg;
endmodule

// File: lcs_wb_regs.sv
// Classic Wishbone slave holding the four cells' source-select registers.
// Assumes a single-cycle classic master that holds its request until ack.
`timescale 1ns/1ns
module lcs_wb_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [lcs_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // selector fields, one register per cell
  output lcs_pkg::lcs_reg_t sel_reg_o [lcs_pkg::NUM_CELLS]
);
  import lcs_pkg::*;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    lcs_reg_t [NUM_CELLS-1:0] sel;
  } lcs_wb_state_t;
  lcs_wb_state_t state;
  lcs_wb_state_t next_state;

  function automatic logic [2:0] decode(input logic [ADR_W-1:0] adr);
    // bit 2 flags a hit, bits 1..0 give the cell
    unique case (adr)
      CELL1_SEL_OFFSET: decode = 3'h4;
      CELL2_SEL_OFFSET: decode = 3'h5;
      CELL3_SEL_OFFSET: decode = 3'h6;
      CELL4_SEL_OFFSET: decode = 3'h7;
      default: decode = 3'h0;
    endcase
  endfunction

  logic [2:0] hit;
  logic [REG_W-1:0] lane_mask;
  always_comb begin
    next_state = state;
    hit = decode(wb_adr_i);
    lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    next_state.ack = 1'b0;
    if (wb_cyc_i && wb_stb_i && !state.ack) begin
      next_state.ack = 1'b1;
      next_state.dat = 32'h0000_0000;
      if (hit[2]) begin
        next_state.dat = {16'h0000, state.sel[hit[1:0]] & SEL_IMPL_MASK};
        if (wb_we_i) begin
          next_state.sel[hit[1:0]] = (state.sel[hit[1:0]] & ~(lane_mask & SEL_IMPL_MASK))
                                   | (wb_dat_i[REG_W-1:0] & lane_mask & SEL_IMPL_MASK);
          next_state.dat = 32'h0000_0000;
        end
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= '{ack: 1'b0, dat: 32'h0000_0000, sel: {NUM_CELLS{SEL_RESET}}};
    end else begin
      state <= next_state;
    end
  end
  assign wb_ack_o = state.ack;
  assign wb_dat_o = state.dat;
  always_comb begin
    for (int c = 0; c < NUM_CELLS; c++) begin
      sel_reg_o[c] = state.sel[c];
    end
  end
endmodule

// File: lcs_top_sva.sv
// Checker on the source select block's ports.
// Assumes a classic Wishbone master; byte lanes 0 and 1 gate the selector bytes.
`timescale 1ns/1ns
module lcs_chk (
  // bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [lcs_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // sources and data lines
  input wire logic logic_cell_input_a_i,
  input wire logic [15:0] data_true_o,
  input wire logic [15:0] data_neg_o
);
  import lcs_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  lcs_reg_t sh [NUM_CELLS];
  logic take;
  logic hit;
  lcs_reg_t lane;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign lane = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & SEL_IMPL_MASK;
  assign hit = wb_adr_i[1:0] == 2'h0 && wb_adr_i < 8'h10;
  // mirror written on the edge a request is taken, as the slave does
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NUM_CELLS; i++) begin
      if (rst_i) begin
        sh[i] <= SEL_RESET;
      end else if (take && wb_we_i && hit && wb_adr_i[3:2] == 2'(i)) begin
        sh[i] <= (sh[i] & ~lane) | (wb_dat_i[15:0] & lane);
      end
    end
  end
  sequence s_read;
    take && !wb_we_i && hit;
  endsequence
  sequence s_quiet;
    sh[0][2:0] == 3'h0 && $stable(logic_cell_input_a_i);
  endsequence
  a_ack_follows: assert property (take |=> wb_ack_o)
    else $error("request not acknowledged");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_caused: assert property (!take |=> !wb_ack_o)
    else $error("ack without request");
  a_unused_zero: assert property (wb_ack_o && !wb_we_i |-> (wb_dat_o & 32'hFFFF8888) == 0)
    else $error("unused bits nonzero");
  a_read_back: assert property (s_read |=> wb_dat_o == {16'h0000, sh[wb_adr_i[3:2]]})
    else $error("read differs from write");
  a_neg_true: assert property (data_neg_o == ~data_true_o)
    else $error("negated line wrong");
  a_reset_lines: assert property ($fell(rst_i) |-> {data_true_o, data_neg_o} == 32'h0000FFFF)
    else $error("lines not cleared");
  a_code_zero: assert property (s_quiet [*4] |-> data_true_o[0] == logic_cell_input_a_i)
    else $error("code zero route wrong");
endmodule
bind lcs_top lcs_chk lcs_chk_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .logic_cell_input_a_i(logic_cell_input_a_i),
  .data_true_o(data_true_o), .data_neg_o(data_neg_o));

// File: lcs_src_model.sv
// Stand-in for the on-chip sources of the selectors.
// Assumes the bench hands it one level word per cycle.
`timescale 1ns/1ns
module lcs_src_model (
  // clock and wanted levels
  input wire logic clk_i,
  input wire logic [50:0] word_i,
  // source levels
  output logic [50:0] src_o
);
  // peripherals move just after an edge, as on chip
  always @(posedge clk_i) begin
    src_o <= word_i;
  end
endmodule

// File: lcs_top_tb.sv
// Bench for the source select block, with a table of expected routes.
// Assumes the source model and the bound checker.
`timescale 1ns/1ns
module lcs_top_tb;
  import lcs_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, ack;
  logic [3:0] sel = 4'hF;
  logic [ADR_W-1:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [50:0] word = '0, s;
  logic [15:0] dt, dn;
  int bad_count = 0, checked = 0;
  // shadow copy of the four selector registers, unused bits already dropped
  int shadow [4] = '{0, 0, 0, 0};
  logic [1:0] lanes = 2'b11;
  // cell*4+mux, then source bit for each code; 99 marks open or untested codes
  int rt [9][9] = '{'{0, 0, 2, 6, 9, 21, 3, 7, 8}, '{4, 0, 2, 6, 11, 23, 3, 7, 8},
    '{8, 0, 99, 99, 13, 99, 3, 7, 19}, '{12, 0, 15, 6, 4, 5, 3, 7, 17},
    '{1, 1, 48, 25, 39, 28, 29, 99, 99}, '{5, 1, 47, 25, 40, 28, 29, 99, 99},
    '{10, 0, 99, 26, 99, 99, 30, 34, 99}, '{14, 0, 99, 26, 99, 99, 30, 34, 99},
    '{3, 1, 48, 27, 45, 31, 32, 18, 14}};
  always #2 clk_i = ~clk_i;
  lcs_src_model lcs_src_model_i (.clk_i(clk_i), .word_i(word), .src_o(s));
  lcs_top lcs_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .logic_cell_input_a_i(s[0]), .logic_cell_input_b_i(s[1]),
    .system_clock_sig_i(s[2]), .hs_pwm_clock_i(s[3]), .internal_oscillator_clock_i(s[4]),
    .reference_clock_output_i(s[5]), .timer1_match_i(s[6]), .timer2_match_i(s[7]),
    .timer3_match_i(s[8]), .pwm_gen_high_i(s[16:9]), .pwm_gen_low_i(s[24:17]),
    .comparator_1_output_i(s[25]), .comparator_2_output_i(s[26]),
    .comparator_3_output_i(s[27]), .adc_end_of_conv_i(s[28]), .dma_ch0_irq_i(s[29]),
    .dma_ch1_irq_i(s[30]), .pattern_trigger_i(s[31]), .can_msg_i(s[32]),
    .pwm_current_reset_i(s[33]), .output_compare_i(s[36:34]),
    .input_capture_i(s[38:37]), .uart_tx_i(s[40:39]), .uart_rx_i(s[42:41]),
    .spi_sdo_i(s[44:43]), .spi_sdi_i(s[46:45]), .cell_out_i(s[50:47]),
    .data_true_o(dt), .data_neg_o(dn));
  task automatic fail(input string m);
    bad_count++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      fail(m);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // one classic cycle; upper byte enables are unused, so they carry noise
  task automatic bus(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= {2'($urandom), lanes};
    // no limit of its own: the watchdog ends a hung wait
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
  endtask
  task automatic read_all(input string m);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0);
      cmp(rdat, 32'(shadow[i]), m);
    end
  endtask
  // about ten times the expected run
  initial begin
    #40000;
    fail("timeout");
    tally_and_finish();
  end
  initial begin
    int c, m, x, p;
    logic [15:0] v;
    void'($urandom(32'hEF03));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    cmp({dt, dn}, 32'h0000FFFF, "reset lines");
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0);
      cmp(rdat, 32'h0, "reset value");
    end
    bus(1'b1, 8'h10, 32'hFFFFFFFF);
    bus(1'b0, 8'h10, 32'h0);
    cmp(rdat, 32'h0, "unmapped read");
    for (int r = 0; r < 9; r++) begin
      p = rt[r][0];
      c = rt[r][0] / 4;
      m = rt[r][0] % 4;
      for (int k = 0; k < 8; k++) begin
        x = rt[r][k + 1];
        if (x != 99) begin
          v = 16'($urandom);
          v[m * 4 +: 3] = 3'(k);
          bus(1'b1, 8'(c * 4), {16'($urandom), v});
          bus(1'b0, 8'(c * 4), 32'h0);
          shadow[c] = int'(v & 16'h7777);
          cmp(rdat, 32'(shadow[c]), "readback");
          // all other sources opposite, so any wrong route shows
          for (int b = 0; b < 2; b++) begin
            word <= b[0] ? 51'(1) << x : ~(51'(1) << x);
            repeat (5) @(posedge clk_i);
            cmp(32'({dt[p], dn[p]}), 32'({b[0], ~b[0]}), "route");
          end
        end
      end
    end
    // lane 0 only: the high selector byte keeps its value
    lanes = 2'b01;
    bus(1'b1, 8'h04, 32'h0000_7777);
    lanes = 2'b11;
    shadow[1] = (shadow[1] & 32'h7700) | 32'h0077;
    read_all("lane write");
    // a reset in mid-run clears every selector again
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    cmp({dt, dn}, 32'h0000FFFF, "reset lines again");
    shadow = '{0, 0, 0, 0};
    read_all("reset value again");
    tally_and_finish();
  end
endmodule
